//--- rtl/sps_port.sv
// Full-duplex serial master/slave port with byte shifter and flags
// What this block does
// - Master: data write starts SCK and shifts eight bits out.
// - Master: after a byte SCK stops and the done flag sets.
// - Done flag with interrupt enable raises interrupt, in both roles.
// - Last received byte is kept in a receive buffer for reading.
// - Slave with select high: idle, MISO off, writes accepted, no shifting.
// - Slave: done flag sets once a full byte is shifted in.
// - Slave may load the next byte before reading the received one.
// - Received byte must be read before next completes, else lost.
// - Master forces MISO input; slave forces MOSI, SCK, select input.
// - MOSI carries master to slave, MISO slave to master, simultaneously.
// - Bit order selectable, LSB first or MSB first.
// - Master offers seven SCK rates, fastest half the CPU clock.
// - Data write during a transfer sets the write collision flag.
// - Port runs while CPU idles; its interrupt can wake it.
// - Done flag clears on vector ack; both flags clear on status read then data access.
// - Master with select input pulled low becomes slave, sets done.
// - Polarity sets SCK idle level; phase picks leading or trailing sample.
// - Slave select high resets slave logic, drops partial bits.
`timescale 1ns/1ns
`default_nettype none
module sps_port (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Software access strobes
   input  wire logic       ctrl_wr,
   input  wire logic [7:0] ctrl_wdata,
   input  wire logic       status_wr,
   input  wire logic       status_wdata,
   input  wire logic       status_rd,
   input  wire logic       data_wr,
   input  wire logic [7:0] data_wdata,
   input  wire logic       data_rd,
   input  wire logic       irq_ack,
   // Software read values
   output var  logic [7:0] serial_ctrl_reg,
   output var  logic [7:0] serial_status_reg,
   output var  logic [7:0] serial_data_reg,
   output var  logic       irq,
   // User pin directions
   input  wire logic       dir_mosi,
   input  wire logic       dir_sck,
   input  wire logic       dir_miso,
   input  wire logic       dir_ss_out,
   // Serial pins
   input  wire logic       spi_sck_in,
   output var  logic       sck_out,
   output var  logic       sck_oe,
   input  wire logic       mosi_in,
   output var  logic       mosi_out,
   output var  logic       mosi_oe,
   input  wire logic       miso_in,
   output wire logic       miso_out,
   output var  logic       miso_oe,
   input  wire logic       ss_n_in
);

   typedef enum logic {SPS_IDLE, SPS_RUN} sps_state_t;

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [7:0] ctrl;
   logic       transfer_done_flag;
   logic       write_collision_flag;
   logic       double_rate_bit;
   logic       clear_armed;
   logic [7:0] tx_reg;
   logic [7:0] rx_buf;
   sps_state_t state;
   logic [7:0] m_sh;
   logic [2:0] m_bitcnt;
   logic       m_half;
   logic       m_done;
   logic       tick;
   logic       slave_off;
   logic       s_tgl_d;
   logic       ss_s;
   logic       miso_s;
   logic       s_tgl_s;
   logic       s_mid_s;
   // Link-domain state
   logic [7:0] s_sh;
   logic [2:0] s_cnt;
   logic       s_mid;
   logic       s_tgl;
   logic [7:0] s_hold;
   logic       s_out;

   logic       en;
   logic       is_master;
   logic       is_slave;
   logic       lsb_first;
   logic       clock_idle_level;
   logic       clock_sample_phase;
   logic       busy;
   logic       start;
   logic       collide;
   logic       ss_fault;
   logic       s_done;
   logic       set_done;
   logic       clr_seq;
   logic       sclk_s;
   logic       slave_rst;

   assign en        = ctrl[sps_pkg::CTRL_ENABLE];
   assign is_master = en & ctrl[sps_pkg::CTRL_MASTER];
   assign is_slave  = en & ~ctrl[sps_pkg::CTRL_MASTER];
   assign lsb_first = ctrl[sps_pkg::CTRL_LSB_1ST];
   assign clock_idle_level      = ctrl[sps_pkg::CTRL_CLOCK_IDLE_LEVEL];
   assign clock_sample_phase      = ctrl[sps_pkg::CTRL_CLOCK_SAMPLE_PHASE];

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   sps_sync #(.W(4)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({ss_n_in, miso_in, s_tgl, s_mid}),
      .q   ({ss_s, miso_s, s_tgl_s, s_mid_s})
   );

   // ************************************************************
   // Master clock generator
   // ************************************************************
   sps_rate u_rate (
      .clk       (clk),
      .rst       (rst),
      .run       (state == SPS_RUN),
      .half_log2 (sps_pkg::RATE_LOG2[{double_rate_bit, ctrl[1:0]}]),
      .tick      (tick)
   );

   // Busy covers the whole shift cycle, including the finishing cycle
   assign busy     = (is_master & ((state == SPS_RUN) | m_done)) | (is_slave & s_mid_s);
   assign collide  = data_wr & busy;
   assign ss_fault = is_master & ~dir_ss_out & ~ss_s;
   assign start    = data_wr & is_master & ~busy & ~ss_fault;
   assign s_done   = is_slave & (s_tgl_s ^ s_tgl_d);
   assign set_done = m_done | s_done | ss_fault;
   assign clr_seq  = clear_armed & (data_rd | data_wr);

   // ************************************************************
   // Control and double-rate bits
   // ************************************************************
   // Hardware drops the master bit when another master selects us
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl            <= sps_pkg::CTRL_RESET;
         double_rate_bit <= 1'b0;
      end
      else
      begin
         if (ctrl_wr)
            ctrl <= ctrl_wdata;
         if (ss_fault)
            ctrl[sps_pkg::CTRL_MASTER] <= 1'b0;
         if (status_wr)
            double_rate_bit <= status_wdata;
      end
   end

   // ************************************************************
   // Transmit byte and receive buffer
   // ************************************************************
   // Colliding writes are dropped so the shifter never sees a torn byte
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tx_reg <= sps_pkg::DATA_RESET;
         rx_buf <= sps_pkg::DATA_RESET;
      end
      else
      begin
         if (data_wr && !busy)
            tx_reg <= data_wdata;
         if (m_done)
            rx_buf <= m_sh;
         else if (s_done)
            rx_buf <= s_hold;
      end
   end

   // ************************************************************
   // Flags and interrupt
   // ************************************************************
   // Set beats clear when both land in one cycle
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         transfer_done_flag   <= 1'b0;
         write_collision_flag <= 1'b0;
         clear_armed          <= 1'b0;
         irq                  <= 1'b0;
      end
      else
      begin
         if (set_done)
            transfer_done_flag <= 1'b1;
         else if (clr_seq || irq_ack)
            transfer_done_flag <= 1'b0;
         if (collide)
            write_collision_flag <= 1'b1;
         else if (clr_seq)
            write_collision_flag <= 1'b0;
         if (status_rd && (transfer_done_flag || write_collision_flag))
            clear_armed <= 1'b1;
         else if (data_rd || data_wr || irq_ack)
            clear_armed <= 1'b0;
         // Plain level, no clock gating, so it can wake an idling CPU
         irq <= transfer_done_flag & ctrl[sps_pkg::CTRL_IRQ_EN];
      end
   end

   // ************************************************************
   // Master shifter
   // ************************************************************
   // Sample on the edge that matches the phase bit, set up on the other
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state    <= SPS_IDLE;
         m_sh     <= 8'h00;
         m_bitcnt <= 3'h0;
         m_half   <= 1'b0;
         m_done   <= 1'b0;
         sck_out  <= 1'b0;
         mosi_out <= 1'b0;
      end
      else if (!is_master)
      begin
         state    <= SPS_IDLE;
         m_bitcnt <= 3'h0;
         m_half   <= 1'b0;
         m_done   <= 1'b0;
         sck_out  <= clock_idle_level;
      end
      else
      begin
         m_done <= 1'b0;
         unique case (state)
            SPS_IDLE:
            begin
               sck_out <= clock_idle_level;
               if (start)
               begin
                  m_sh     <= data_wdata;
                  mosi_out <= sps_pkg::out_bit(data_wdata, lsb_first);
                  m_bitcnt <= 3'h0;
                  m_half   <= 1'b0;
                  state    <= SPS_RUN;
               end
            end
            SPS_RUN:
            begin
               if (tick)
               begin
                  sck_out <= ~sck_out;
                  m_half  <= ~m_half;
                  if (m_half == clock_sample_phase)
                     m_sh <= sps_pkg::shift_in(m_sh, lsb_first, miso_s);
                  else
                     mosi_out <= sps_pkg::out_bit(m_sh, lsb_first);
                  if (m_half)
                  begin
                     m_bitcnt <= 3'(m_bitcnt + 3'h1);
                     if (m_bitcnt == 3'(sps_pkg::BITS_PER_BYTE - 1))
                     begin
                        state  <= SPS_IDLE;
                        m_done <= 1'b1;
                     end
                  end
               end
            end
         endcase
      end
   end

   // ************************************************************
   // Pin direction overrides
   // ************************************************************
   // Slave select is never driven here; software owns it as a GPIO
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sck_oe    <= 1'b0;
         mosi_oe   <= 1'b0;
         miso_oe   <= 1'b0;
         slave_off <= 1'b1;
         s_tgl_d   <= 1'b0;
      end
      else
      begin
         sck_oe    <= is_master & dir_sck;
         mosi_oe   <= is_master & dir_mosi;
         miso_oe   <= is_slave & dir_miso & ~ss_s;
         slave_off <= ~is_slave;
         s_tgl_d   <= is_slave ? s_tgl_s : 1'b0;
      end
   end

   // ************************************************************
   // Slave shifter on the link clock
   // ************************************************************
   // Sampling edge becomes a rising edge for every polarity and phase
   assign sclk_s    = spi_sck_in ^ clock_idle_level ^ clock_sample_phase;
   assign slave_rst = ss_n_in | slave_off;

   // Select high clears the frame at once, partial bits are gone
   always_ff @(posedge sclk_s or posedge slave_rst)
   begin
      if (slave_rst)
      begin
         s_sh  <= 8'h00;
         s_cnt <= 3'h0;
         s_mid <= 1'b0;
      end
      else
      begin
         s_sh  <= sps_pkg::shift_in((s_cnt == 3'h0) ? tx_reg : s_sh, lsb_first, mosi_in);
         s_cnt <= 3'(s_cnt + 3'h1);
         s_mid <= (s_cnt != 3'(sps_pkg::BITS_PER_BYTE - 1));
      end
   end

   // Completed byte is held steady while its toggle crosses over
   always_ff @(posedge sclk_s or posedge slave_off)
   begin
      if (slave_off)
      begin
         s_tgl  <= 1'b0;
         s_hold <= 8'h00;
      end
      else if (s_cnt == 3'(sps_pkg::BITS_PER_BYTE - 1))
      begin
         s_hold <= sps_pkg::shift_in(s_sh, lsb_first, mosi_in);
         s_tgl  <= ~s_tgl;
      end
   end

   // Set-up edge of the slave; first bit of a byte comes from the data byte
   always_ff @(negedge sclk_s or posedge slave_rst)
   begin
      if (slave_rst)
         s_out <= 1'b0;
      else if (s_cnt == 3'h0)
         s_out <= sps_pkg::out_bit(tx_reg, lsb_first);
      else
         s_out <= sps_pkg::out_bit(s_sh, lsb_first);
   end

   // Leading-edge sampling needs bit one on the pin before any edge
   assign miso_out = (s_cnt == 3'h0 && !clock_sample_phase) ? sps_pkg::out_bit(tx_reg, lsb_first) : s_out;

   // ************************************************************
   // Software read values
   // ************************************************************
   assign serial_ctrl_reg   = ctrl;
   assign serial_status_reg = {transfer_done_flag, write_collision_flag, 5'h00, double_rate_bit};
   assign serial_data_reg   = rx_buf;

endmodule : sps_port
`default_nettype wire

//--- rtl/sps_pkg.sv
// Shared constants and helper functions of the serial master/slave port
package sps_pkg;

   // ************************************************************
   // Control byte field positions
   // ************************************************************
   localparam int CTRL_IRQ_EN  = 7;
   localparam int CTRL_ENABLE  = 6;
   localparam int CTRL_LSB_1ST = 5;
   localparam int CTRL_MASTER  = 4;
   localparam int CTRL_CLOCK_IDLE_LEVEL    = 3;
   localparam int CTRL_CLOCK_SAMPLE_PHASE    = 2;
   localparam int CTRL_RATE_HI = 1;
   localparam int CTRL_RATE_LO = 0;

   // ************************************************************
   // Status byte field positions
   // ************************************************************
   localparam int STAT_DONE   = 7;
   localparam int STAT_COLL   = 6;
   localparam int STAT_DOUBLE = 0;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // ************************************************************
   // Timing
   // ************************************************************
   // Least SCK low or high phase, in CPU clock cycles, for the slave role
   localparam int SCK_MIN_PHASE_CYC = 2;
   // Log2 of the SCK half period in CPU cycles, indexed {double, rate[1:0]}
   localparam logic [2:0] RATE_LOG2 [0:7] = '{3'h1, 3'h3, 3'h5, 3'h6,
                                              3'h0, 3'h2, 3'h4, 3'h5};
   localparam int BITS_PER_BYTE = 8;

   // Bit that leaves the shift register next
   function automatic logic out_bit(input logic [7:0] b, input logic lsb_first);
      out_bit = lsb_first ? b[0] : b[7];
   endfunction : out_bit

   // Shift one bit out and one bit in
   function automatic logic [7:0] shift_in(input logic [7:0] b,
                                           input logic       lsb_first,
                                           input logic       din);
      shift_in = lsb_first ? {din, b[7:1]} : {b[6:0], din};
   endfunction : shift_in

endpackage : sps_pkg

//--- rtl/sps_sync.sv
// Two-flop level synchroniser, one lane per bit
`timescale 1ns/1ns
`default_nettype none
module sps_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Levels in and out
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] stage1;

   // First stage feeds only the second; no logic looks at it
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stage1 <= '0;
         q      <= '0;
      end
      else
      begin
         stage1 <= d;
         q      <= stage1;
      end
   end

endmodule : sps_sync
`default_nettype wire

//--- rtl/sps_rate.sv
// SCK half-period tick generator for the master role
`timescale 1ns/1ns
`default_nettype none
module sps_rate (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Control
   input  wire logic       run,
   input  wire logic [2:0] half_log2,
   // Tick, one cycle per SCK edge
   output var  logic       tick
);

   logic [6:0] count;
   logic [6:0] limit;

   // Half period minus one; 0 at the fastest rate
   assign limit = 7'((8'h01 << half_log2) - 8'h01);

   // Counter restarts whenever a transfer is not running
   always_ff @(posedge clk)
   begin
      if (rst || !run)
      begin
         count <= 7'h00;
         tick  <= 1'b0;
      end
      else if (count >= limit)
      begin
         count <= 7'h00;
         tick  <= 1'b1;
      end
      else
      begin
         count <= 7'(count + 7'h01);
         tick  <= 1'b0;
      end
   end

endmodule : sps_rate
`default_nettype wire

//--- bench/sps_peer.sv
// Behavioural remote device: slave to our master, master to our slave
`timescale 1ns/1ns
`default_nettype none
module sps_peer (
   // Slave side pins
   input  wire logic sck,
   input  wire logic mosi,
   input  wire logic ss_n,
   input  wire logic lsb,
   output var  logic miso,
   // Master side pins
   input  wire logic m_miso,
   output var  logic m_sck,
   output var  logic m_mosi
);
   // ***
   // Remote slave, mode 0
   // ***
   logic [7:0] sh  = 8'h00;
   logic       inb = 1'b0;

   // Quiet pins at time zero
   initial
   begin
      miso = 1'b0;
      m_sck = 1'b0;
      m_mosi = 1'b0;
   end

   // Sample on the leading edge
   always @(posedge sck)
      if (!ss_n)
         inb <= mosi;

   // Shift in and set up the next bit on the trailing edge
   always @(negedge sck)
      if (!ss_n)
      begin
         sh = lsb ? {inb, sh[7:1]} : {sh[6:0], inb};
         miso <= lsb ? sh[0] : sh[7];
      end

   // First bit on select; a released line must not keep a stale bit
   always @(negedge ss_n)
      miso <= lsb ? sh[0] : sh[7];
   always @(posedge ss_n)
      miso <= ~miso;

   // ***
   // Remote master, mode 0, MSB first, clock only inside frames
   // ***
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      #13;
      for (int i = 0; i < nbits; i++)
      begin
         m_mosi = tx[7 - i];
         #32 m_sck = 1'b1;
         rx = {rx[6:0], m_miso};
         #32 m_sck = 1'b0;
      end
      m_mosi = ~m_mosi;
   endtask : xfer
endmodule : sps_peer
`default_nettype wire

//--- bench/sps_port_chk.sv
// Port-level property checker for the serial port
`timescale 1ns/1ns
`default_nettype none
module sps_port_chk (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Strobes and pins in
   input wire logic       data_wr,
   input wire logic       data_rd,
   input wire logic       irq_ack,
   input wire logic       ss_n_in,
   // Watched outputs
   input wire logic [7:0] serial_ctrl_reg,
   input wire logic [7:0] serial_status_reg,
   input wire logic       irq,
   input wire logic       sck_out,
   input wire logic       sck_oe,
   input wire logic       mosi_oe,
   input wire logic       miso_oe
);
   // ***
   // Properties
   // ***
   // Single domain, reset disables all
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);

   irq_follow_a:
      assert property (irq == ($past(serial_status_reg[7]) && $past(serial_ctrl_reg[7])))
      else $error("irq not tied to flag and enable");
   miso_quiet_a:
      assert property (ss_n_in [*5] |-> !miso_oe)
      else $error("miso driven while deselected");
   master_miso_a:
      assert property (serial_ctrl_reg[4] ##1 serial_ctrl_reg[4] |-> !miso_oe)
      else $error("miso driven in master role");
   slave_pins_a:
      assert property (!serial_ctrl_reg[4] ##1 !serial_ctrl_reg[4] |-> !sck_oe && !mosi_oe)
      else $error("sck or mosi driven in slave role");
   coll_set_a:
      assert property (data_wr && serial_ctrl_reg[4] && sck_out != serial_ctrl_reg[3]
                       |=> serial_status_reg[6])
      else $error("collision not flagged");
   flag_clear_a:
      assert property ($fell(serial_status_reg[7])
                       |-> $past(irq_ack) || $past(data_rd) || $past(data_wr))
      else $error("done flag cleared without cause");
   sck_idle_a:
      assert property ($rose(serial_status_reg[7]) && serial_ctrl_reg[4]
                       |-> sck_out == serial_ctrl_reg[3])
      else $error("sck not idle after byte");
   sck_rate_a:
      assert property (serial_ctrl_reg[4] && !serial_status_reg[0] && $changed(sck_out)
                       |=> $stable(sck_out))
      else $error("sck phase shorter than two cycles");
endmodule : sps_port_chk

bind sps_port sps_port_chk u_chk (.clk(clk), .rst(rst), .data_wr(data_wr), .data_rd(data_rd),
   .irq_ack(irq_ack), .ss_n_in(ss_n_in), .serial_ctrl_reg(serial_ctrl_reg),
   .serial_status_reg(serial_status_reg), .irq(irq), .sck_out(sck_out), .sck_oe(sck_oe),
   .mosi_oe(mosi_oe), .miso_oe(miso_oe));
`default_nettype wire

//--- bench/sps_port_tb.sv
// Self-checking bench for the serial master/slave port
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
   $display("BAD %0t got %h want %h", $time, a, b); end end
module sps_port_tb;
   // ***
   // Signals
   // ***
   logic       clk = 1'b0, rst = 1'b1, ctrl_wr = 1'b0, status_wr = 1'b0, status_rd = 1'b0;
   logic       data_wr = 1'b0, data_rd = 1'b0, irq_ack = 1'b0, status_wdata = 1'b0;
   logic       dir_ss_out = 1'b1, ss_n = 1'b1, lsb_p = 1'b0, sck_q = 1'b0;
   logic [7:0] ctrl_wdata = 8'h00, data_wdata = 8'h00;
   logic [7:0] serial_ctrl_reg, serial_status_reg, serial_data_reg;
   logic       irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
   logic       p_miso, m_sck, m_mosi;
   int         num_errors = 0, n_compared = 0, tog = 0, cyc = 0, t0 = 0, tl = 0;
   int         div [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
   localparam int K_CTRL = 0, K_SWR = 1, K_DWR = 2, K_SRD = 3, K_DRD = 4, K_ACK = 5;
   // Resolved pin levels from every party's enable
   wire logic  sck_w  = sck_oe ? sck_out : m_sck;
   wire logic  mosi_w = mosi_oe ? mosi_out : m_mosi;
   wire logic  miso_w = miso_oe ? miso_out : p_miso;

   // 20 MHz CPU clock
   always #25 clk = ~clk;

   sps_port u_dut (.clk(clk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
      .status_wr(status_wr), .status_wdata(status_wdata), .status_rd(status_rd),
      .data_wr(data_wr), .data_wdata(data_wdata), .data_rd(data_rd), .irq_ack(irq_ack),
      .serial_ctrl_reg(serial_ctrl_reg), .serial_status_reg(serial_status_reg),
      .serial_data_reg(serial_data_reg), .irq(irq), .dir_mosi(1'b1), .dir_sck(1'b1),
      .dir_miso(1'b1), .dir_ss_out(dir_ss_out), .spi_sck_in(sck_w), .sck_out(sck_out),
      .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
      .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n));
   sps_peer u_peer (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_n), .lsb(lsb_p), .miso(p_miso),
      .m_miso(miso_w), .m_sck(m_sck), .m_mosi(m_mosi));

   // Count SCK edges and where the first and last fell
   always @(negedge clk)
   begin
      cyc++;
      if (sck_out !== sck_q)
      begin
         if (tog == 0)
            t0 = cyc;
         tl = cyc;
         tog++;
      end
      sck_q = sck_out;
   end

   // One-cycle software access of kind k
   task automatic acc(input int k, input logic [7:0] v);
      @(posedge clk);
      {irq_ack, data_rd, status_rd, data_wr, status_wr, ctrl_wr} <= 6'h01 << k;
      ctrl_wdata <= v;
      data_wdata <= v;
      status_wdata <= v[0];
      @(posedge clk);
      {irq_ack, data_rd, status_rd, data_wr, status_wr, ctrl_wr} <= 6'h00;
   endtask : acc

   // Status read then data read drops both flags
   task automatic clear_flags();
      acc(K_SRD, 8'h00);
      acc(K_DRD, 8'h00);
      @(negedge clk);
      `CHK(serial_status_reg[7:6], 2'h0)
   endtask : clear_flags

   // Master byte at each of the eight rate settings, both bit orders
   task automatic master_rates();
      logic [7:0] tx;
      for (int i = 0; i < 8; i++)
      begin
         tx = 8'hA5 ^ i[7:0];
         lsb_p = i[0];
         u_peer.sh = 8'h3C + i[7:0];
         acc(K_CTRL, 8'hD0 | {2'h0, i[0], 3'h0, i[1:0]});
         acc(K_SWR, {7'h00, i[2]});
         ss_n <= 1'b0;
         acc(K_DWR, tx);
         tog = 0;
         if (div[i] > 8)
         begin
            // Collision mid-byte; slow rates only so sck is away from idle
            repeat (div[i] * 3 / 4) @(negedge clk);
            acc(K_DWR, 8'hFF);
         end
         while (serial_status_reg[7] !== 1'b1 && tog < 40)
            @(negedge clk);
         repeat (2) @(negedge clk);
         `CHK(tog, 16)
         `CHK(tl - t0, 15 * div[i] / 2)
         `CHK(u_peer.sh, tx)
         `CHK(serial_status_reg[7:6], {1'b1, div[i] > 8})
         `CHK(irq, 1'b1)
         `CHK(sck_out, 1'b0)
         if (div[i] > 8)
            `CHK(serial_data_reg, 8'h3C + i[7:0])
         @(posedge clk) ss_n <= 1'b1;
         clear_flags();
      end
   endtask : master_rates

   // Select pulled low on a master with select as input
   task automatic ss_fault();
      @(posedge clk) dir_ss_out <= 1'b0;
      acc(K_CTRL, 8'h50);
      ss_n <= 1'b0;
      repeat (6) @(negedge clk);
      `CHK(serial_ctrl_reg[4], 1'b0)
      `CHK(serial_status_reg[7], 1'b1)
      @(posedge clk) ss_n <= 1'b1;
      dir_ss_out <= 1'b1;
      acc(K_ACK, 8'h00);
      @(negedge clk);
      `CHK(serial_status_reg[7], 1'b0)
   endtask : ss_fault

   // Slave role: deselected load, aborted frame, two bytes
   task automatic slave_xfer();
      logic [7:0] rx;
      acc(K_CTRL, 8'hC0);
      acc(K_DWR, 8'h5A);
      repeat (5) @(negedge clk);
      `CHK(miso_oe, 1'b0)
      @(posedge clk) ss_n <= 1'b0;
      repeat (4) @(negedge clk);
      u_peer.xfer(8'hFF, 3, rx);
      @(posedge clk) ss_n <= 1'b1;
      repeat (6) @(negedge clk);
      `CHK(serial_status_reg[7], 1'b0)
      @(posedge clk) ss_n <= 1'b0;
      repeat (4) @(negedge clk);
      `CHK(miso_oe, 1'b1)
      u_peer.xfer(8'hC3, 8, rx);
      repeat (8) @(negedge clk);
      `CHK(serial_status_reg[7], 1'b1)
      `CHK(serial_data_reg, 8'hC3)
      `CHK(rx, 8'h5A)
      `CHK(irq, 1'b1)
      acc(K_DWR, 8'h69);
      u_peer.xfer(8'h96, 8, rx);
      repeat (8) @(negedge clk);
      `CHK(rx, 8'h69)
      `CHK(serial_data_reg, 8'h96)
      @(posedge clk) ss_n <= 1'b1;
      clear_flags();
   endtask : slave_xfer

   // Counts, verdict and end of run
   task automatic complete_run();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run

   // Main sequence after a 20-cycle reset
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      master_rates();
      ss_fault();
      slave_xfer();
      complete_run();
   end

   // Watchdog: tests need about 2800 cycles, allow 10000
   initial
   begin
      #500000;
      num_errors++;
      complete_run();
   end
endmodule : sps_port_tb
`default_nettype wire
